// ===== rtl/cmd_device.sv
// cell monitor command decoder with configuration and cell result groups
`timescale 1ns/1ps
// Function
// - 0x01 writes whole configuration group
// - 0x02 reads configuration group in order
// - 0x04 reads packed cell results
// - 0x06 reads flag group
// - 0x08 reads temperature group
// - 0x1x starts cell conversion, polls status
// - nibble 0 all cells, 1..C one
// - cells 11-12 only in twelve-cell; D unused
// - nibble E gives 0x555, F 0xAAA
// - 0x2x open-wire conversions, same encoding
// - 0x30-0x33 temperature, 0x34-0x3D unused
// - 0x3E temp self-test code 0x01, 0x3F 0x02; temps not written
// - 0x40 polls busy, 0x50 interrupts
// - 0x6x cell conversion with discharge
// - 0x7x open-wire with discharge
// - last three result bytes need twelve-cell mode
// - crc-8 follows every group read
// - poll low if busy (0x50: if interrupt pending), else toggle/level
// - host holds select low, raises to end
module cmd_device
   import cmd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   cmd_link_if.device link,
   input wire logic [11:0] conv_value,
   input wire logic [1:0] temp_status,
   input wire logic [23:0] flag_bits,
   input wire logic int_pending,
   output logic busy,
   output logic discharge_active,
   output logic [3:0] conv_kind,
   output logic [3:0] conv_channel,
   output logic [47:0] config_group,
   output logic [7:0] temp_self_test
);
   typedef struct packed {
      logic [2:0] cs_sync;
      logic [2:0] sck_sync;
      logic [1:0] sdi_sync;
      cmd_state_e state;
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [7:0] cmd;
      logic [4:0] byte_idx;
      logic [47:0] cfg;
      logic [47:0] cfg_stage;
      logic [143:0] cells;
      logic [7:0] out_byte;
      logic [7:0] crc;
      logic crc_sent;
      logic sdo;
      logic [15:0] busy_cnt;
      logic [3:0] kind;
      logic [3:0] chan;
      logic discharge;
      logic [7:0] tst;
      logic [15:0] tog_cnt;
      logic tog;
   } dev_s;
   dev_s q, d;

   // group length in bytes for a read command; zero means not a group read
   function automatic logic [4:0] group_len(input logic [7:0] c, input logic ten);
      case (c)
         CMD_READ_CONFIG: group_len = 5'(CONFIG_BYTES);
         CMD_READ_CELLS: group_len = ten ? 5'(CELL_BYTES_TEN) : 5'(CELL_BYTES);
         CMD_READ_FLAGS: group_len = 5'(FLAG_BYTES);
         CMD_READ_TEMPS: group_len = 5'(TEMP_BYTES);
         default: group_len = 5'd0;
      endcase
   endfunction

   // byte of the addressed group at index i
   function automatic logic [7:0] group_byte(input logic [7:0] c, input logic [4:0] i, input dev_s s);
      case (c)
         CMD_READ_CONFIG: group_byte = s.cfg[8*i +: 8];
         CMD_READ_CELLS: group_byte = s.cells[8*i +: 8];
         CMD_READ_FLAGS: group_byte = flag_bits[8*i +: 8];
         default: group_byte = 8'h00; // temperature values come from the converter side, not held here
      endcase
   endfunction

   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] b);
      logic [7:0] r;
      r = crc ^ b;
      for (int k = 0; k < 8; k++) begin
         r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
      crc_step = r;
   endfunction

   logic sck_rise, sck_fall, cs_low, cs_rise, ten;

   always_comb begin
      d = q;
      d.cs_sync = {q.cs_sync[1:0], link.chip_select_in_n};
      d.sck_sync = {q.sck_sync[1:0], link.sck};
      d.sdi_sync = {q.sdi_sync[0], link.sdi};
      sck_rise = q.sck_sync[1] & ~q.sck_sync[2];
      sck_fall = ~q.sck_sync[1] & q.sck_sync[2];
      cs_low = ~q.cs_sync[1];
      cs_rise = q.cs_sync[1] & ~q.cs_sync[2];
      ten = q.cfg[TEN_CELL_BIT];
      // conversion timebase; results land when it runs out
      if (q.busy_cnt != 16'd0) begin
         d.busy_cnt = q.busy_cnt - 16'd1;
         if (q.busy_cnt == 16'd1 && q.kind != FAM_TEMP) begin // open-wire results land in cells too
            for (int n = 0; n < 12; n++) begin
               if (q.chan == SUB_SELF_TEST1) begin
                  d.cells[12*n +: 12] = SELF_TEST1_VALUE;
               end else if (q.chan == SUB_SELF_TEST2) begin
                  d.cells[12*n +: 12] = SELF_TEST2_VALUE;
               end else if ((q.chan == SUB_ALL && !(ten && n >= 10)) || q.chan == 4'(n + 1)) begin
                  d.cells[12*n +: 12] = conv_value;
               end
            end
         end
      end
      // 1 khz toggle for polling
      if (q.tog_cnt == 16'(TOGGLE_HALF_CYCLES - 1)) begin
         d.tog_cnt = 16'd0;
         d.tog = ~q.tog;
      end else begin
         d.tog_cnt = q.tog_cnt + 16'd1;
      end
      // link sequencer
      if (!cs_low) begin
         if (cs_rise && q.state == CMD_DATA_E && q.cmd == CMD_WRITE_CONFIG && q.byte_idx >= 5'(CONFIG_BYTES)) begin
            d.cfg = q.cfg_stage; // data latched on select release
         end
         d.state = CMD_IDLE_E;
         d.bit_cnt = 3'd0;
         d.byte_idx = 5'd0;
         d.sdo = 1'b1;
      end else begin
         case (q.state)
            CMD_IDLE_E: begin
               if (sck_rise) begin
                  d.shift = {q.shift[6:0], q.sdi_sync[1]};
                  d.bit_cnt = q.bit_cnt + 3'd1;
                  if (q.bit_cnt == 3'd7) begin
                     d.cmd = {q.shift[6:0], q.sdi_sync[1]};
                     d.state = CMD_DATA_E;
                     d.byte_idx = 5'd0;
                     d.crc = 8'h00;
                     d.crc_sent = 1'b0;
                     d.out_byte = group_byte(d.cmd, 5'd0, q);
                     case (d.cmd[7:4])
                        FAM_CELL, FAM_OPEN_WIRE, FAM_CELL_DISCHARGE, FAM_OPEN_WIRE_DISCHARGE: begin
                           if (d.cmd[3:0] == SUB_UNUSED_CELL || (ten && d.cmd[3:0] >= SUB_CELL_ELEVEN
                                 && d.cmd[3:0] <= SUB_LAST_CELL)) begin
                              d.state = CMD_DROP_E;
                           end else begin
                              d.kind = d.cmd[7:4];
                              d.chan = d.cmd[3:0];
                              d.discharge = d.cmd[6];
                              d.busy_cnt = 16'(CONV_CYCLES);
                              d.state = CMD_POLL_E;
                           end
                        end
                        FAM_TEMP: begin
                           if (d.cmd[3:0] > SUB_TEMP_LAST && d.cmd[3:0] < SUB_SELF_TEST1) begin
                              d.state = CMD_DROP_E;
                           end else begin
                              d.kind = FAM_TEMP;
                              d.chan = d.cmd[3:0];
                              d.discharge = 1'b0;
                              d.tst = (d.cmd[3:0] == SUB_SELF_TEST1) ? 8'h01 :
                                 (d.cmd[3:0] == SUB_SELF_TEST2) ? 8'h02 : 8'h00;
                              d.busy_cnt = 16'(CONV_CYCLES);
                              d.state = CMD_POLL_E;
                           end
                        end
                        default: begin
                           if (d.cmd == CMD_POLL_BUSY || d.cmd == CMD_POLL_INT) begin
                              d.state = CMD_POLL_E;
                           end else if (d.cmd != CMD_WRITE_CONFIG && group_len(d.cmd, ten) == 5'd0) begin
                              d.state = CMD_DROP_E;
                           end
                        end
                     endcase
                  end
               end
            end
            CMD_DATA_E: begin
               if (q.cmd == CMD_WRITE_CONFIG) begin
                  if (sck_rise && q.byte_idx < 5'(CONFIG_BYTES)) begin
                     d.shift = {q.shift[6:0], q.sdi_sync[1]};
                     d.bit_cnt = q.bit_cnt + 3'd1;
                     if (q.bit_cnt == 3'd7) begin
                        d.cfg_stage[8*q.byte_idx +: 8] = {q.shift[6:0], q.sdi_sync[1]};
                        d.byte_idx = q.byte_idx + 5'd1;
                     end
                  end
               end else if (sck_fall && !q.crc_sent) begin
                  // drive msb first on falling edge, shift a byte every eight bits
                  d.sdo = q.out_byte[7];
                  d.out_byte = {q.out_byte[6:0], 1'b0};
                  d.bit_cnt = q.bit_cnt + 3'd1;
                  if (q.bit_cnt == 3'd7) begin
                     if (q.byte_idx == group_len(q.cmd, ten)) begin
                        d.crc_sent = 1'b1; // passes chained data after that, not modelled
                     end else begin
                        d.crc = crc_step(q.crc, group_byte(q.cmd, q.byte_idx, q));
                        d.byte_idx = q.byte_idx + 5'd1;
                        d.out_byte = (q.byte_idx + 5'd1 == group_len(q.cmd, ten)) ?
                           crc_step(q.crc, group_byte(q.cmd, q.byte_idx, q)) :
                           group_byte(q.cmd, q.byte_idx + 5'd1, q);
                     end
                  end
               end
            end
            CMD_POLL_E: begin
               // sck ignored; low while busy, for 0x50 while an interrupt is pending instead
               if ((q.cmd == CMD_POLL_INT) ? int_pending : (q.busy_cnt != 16'd0)) begin
                  d.sdo = 1'b0;
               end else begin
                  d.sdo = q.cfg[LEVEL_POLL_BIT] ? 1'b1 : q.tog;
               end
            end
            default: d.sdo = 1'b1; // ignored command, stay quiet until select rises
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.cs_sync <= 3'b111;
         q.sck_sync <= 3'b111;
         q.sdo <= 1'b1;
         q.cfg <= {40'h00_0000_0000, CONFIG0_RESET};
         q.state <= CMD_IDLE_E;
      end else begin
         q <= d;
      end
   end

   assign link.sdo = q.sdo;
   assign busy = (q.busy_cnt != 16'd0);
   assign discharge_active = q.discharge && (q.busy_cnt != 16'd0);
   assign conv_kind = q.kind;
   assign conv_channel = q.chan;
   assign config_group = q.cfg;
   assign temp_self_test = q.tst;
endmodule

// ===== rtl/cmd_host.sv
// host end: axi4-lite registers drive command bytes over the serial link
`timescale 1ns/1ps
module cmd_host
   import cmd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   cmd_link_if.host link,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      logic aw_got;
      logic [4:0] aw;
      logic w_got;
      logic [7:0] wd;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic cs_n;
      logic sck;
      logic sdi;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [2:0] bits;
      logic xfer;
      logic phase;
      logic [3:0] div;
      logic [1:0] sdo_sync;
   } host_s;
   host_s q, d;
   logic wr_fire;

   // byte engine: falling edge drives, rising edge samples (mode 3)
   always_comb begin
      d = q;
      d.sdo_sync = {q.sdo_sync[0], link.sdo};
      if (s_axi_awvalid && !q.aw_got) begin
         d.aw_got = 1'b1;
         d.aw = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_got) begin
         d.w_got = 1'b1;
         d.wd = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      wr_fire = q.aw_got && q.w_got && !q.bvalid;
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (q.aw)
            REG_CTRL: d.cs_n = ~q.wd[0]; // bit0 holds select low for a whole sequence
            REG_TXDATA: begin
               if (!q.xfer) begin
                  d.tx = q.wd;
                  d.bits = 3'd0;
                  d.xfer = 1'b1;
                  d.phase = 1'b0;
                  d.div = 4'd0;
               end
            end
            default: d.bresp = RESP_SLVERR;
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL: d.rdata = {31'h0, ~q.cs_n};
            REG_STATUS: d.rdata = {30'h0, q.sdo_sync[1], q.xfer}; // live sdo shows poll state
            REG_RXDATA: d.rdata = {24'h0, q.rx};
            default: begin
               d.rdata = 32'h0;
               d.rresp = RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      // serial clock divider, idles high
      if (q.xfer) begin
         if (q.div == 4'(LINK_HALF_CYCLES - 1)) begin
            d.div = 4'd0;
            if (!q.phase) begin
               d.sck = 1'b0;
               d.sdi = q.tx[7];
               d.tx = {q.tx[6:0], 1'b0};
            end else begin
               d.sck = 1'b1;
               d.rx = {q.rx[6:0], q.sdo_sync[1]};
               d.bits = q.bits + 3'd1;
               if (q.bits == 3'd7) begin
                  d.xfer = 1'b0;
               end
            end
            d.phase = ~q.phase;
         end else begin
            d.div = q.div + 4'd1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
         q.cs_n <= 1'b1;
         q.sck <= 1'b1;
         q.sdi <= 1'b1;
         q.sdo_sync <= 2'b11;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = !q.aw_got;
   assign s_axi_wready = !q.w_got;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign link.chip_select_in_n = q.cs_n;
   assign link.sck = q.sck;
   assign link.sdi = q.sdi;
endmodule

// ===== rtl/cmd_link_if.sv
// interface: four-wire serial link between host and cell monitor
`timescale 1ns/1ps
interface cmd_link_if;
   logic chip_select_in_n;
   logic sck;
   logic sdi;
   logic sdo;
   modport host (output chip_select_in_n, output sck, output sdi, input sdo);
   modport device (input chip_select_in_n, input sck, input sdi, output sdo);
endinterface

// ===== rtl/cmd_pkg.sv
// package: command codes, config layout, timing constants for the cell monitor link
package cmd_pkg;
   localparam logic [7:0] CMD_WRITE_CONFIG = 8'h01;
   localparam logic [7:0] CMD_READ_CONFIG = 8'h02;
   localparam logic [7:0] CMD_READ_CELLS = 8'h04;
   localparam logic [7:0] CMD_READ_FLAGS = 8'h06;
   localparam logic [7:0] CMD_READ_TEMPS = 8'h08;
   localparam logic [3:0] FAM_CELL = 4'h1;
   localparam logic [3:0] FAM_OPEN_WIRE = 4'h2;
   localparam logic [3:0] FAM_TEMP = 4'h3;
   localparam logic [3:0] FAM_CELL_DISCHARGE = 4'h6;
   localparam logic [3:0] FAM_OPEN_WIRE_DISCHARGE = 4'h7;
   localparam logic [7:0] CMD_POLL_BUSY = 8'h40;
   localparam logic [7:0] CMD_POLL_INT = 8'h50;
   localparam logic [3:0] SUB_ALL = 4'h0;
   localparam logic [3:0] SUB_LAST_CELL = 4'hc;
   localparam logic [3:0] SUB_CELL_ELEVEN = 4'hb;
   localparam logic [3:0] SUB_UNUSED_CELL = 4'hd;
   localparam logic [3:0] SUB_TEMP_LAST = 4'h3;
   localparam logic [3:0] SUB_SELF_TEST1 = 4'he;
   localparam logic [3:0] SUB_SELF_TEST2 = 4'hf;
   localparam logic [11:0] SELF_TEST1_VALUE = 12'h555;
   localparam logic [11:0] SELF_TEST2_VALUE = 12'haaa;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam int CONFIG_BYTES = 6;
   localparam int CELL_BYTES = 18;
   localparam int CELL_BYTES_TEN = 15;
   localparam int FLAG_BYTES = 3;
   localparam int TEMP_BYTES = 5;
   localparam int TEN_CELL_BIT = 3;
   localparam int LEVEL_POLL_BIT = 4;
   localparam logic [7:0] CONFIG0_RESET = 8'h00;
   localparam int CLK_HZ = 100_000_000;
   localparam int TOGGLE_HZ = 1000;
   localparam int TOGGLE_HALF_CYCLES = CLK_HZ / (2 * TOGGLE_HZ);
   localparam int LINK_HALF_CYCLES = 8;
   localparam int CONV_CYCLES = 1000;
   // host register map, word aligned
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_TXDATA = 5'h08;
   localparam logic [4:0] REG_RXDATA = 5'h0c;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {CMD_IDLE_E, CMD_DATA_E, CMD_POLL_E, CMD_DROP_E} cmd_state_e;
endpackage

// ===== tb/cmd_monitor.sv
// checker: framing and timing of the serial link between host and monitor ends
`timescale 1ns/1ps
module cmd_monitor
   import cmd_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic chip_select_in_n,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo
);
   logic sck_q;
   logic [2:0] bits_q;
   logic [3:0] idle_q;
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // rises per frame modulo a byte; idle time saturates so it never wraps
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_q <= 1'b1;
         bits_q <= 3'h0;
         idle_q <= 4'h0;
      end else begin
         sck_q <= sck;
         bits_q <= chip_select_in_n ? 3'h0 : bits_q + {2'h0, sck & ~sck_q};
         idle_q <= !chip_select_in_n ? 4'h0 : ((idle_q == 4'hf) ? idle_q : idle_q + 4'h1);
      end
   end
   property p_sck_idle_high;
      chip_select_in_n |-> sck;
   endproperty
   a_sck_idle_high: assert property (p_sck_idle_high) else $error("sck low while deselected");
   property p_sck_low_phase;
      $fell(sck) |-> (!sck) [*8] ##1 sck;
   endproperty
   a_sck_low_phase: assert property (p_sck_low_phase) else $error("sck low phase not 8 cycles");
   property p_sck_high_phase;
      $rose(sck) |-> sck [*8];
   endproperty
   a_sck_high_phase: assert property (p_sck_high_phase) else $error("sck high phase too short");
   property p_sdi_hold;
      $rose(sck) |-> ##1 $stable(sdi) [*2];
   endproperty
   a_sdi_hold: assert property (p_sdi_hold) else $error("sdi moved after sck rise");
   property p_cs_setup;
      $fell(sck) |-> !$past(chip_select_in_n, 3);
   endproperty
   a_cs_setup: assert property (p_cs_setup) else $error("sck edge too soon after select");
   property p_cs_rise_sck_high;
      $rose(chip_select_in_n) |-> sck && $past(sck);
   endproperty
   a_cs_rise_sck_high: assert property (p_cs_rise_sck_high) else $error("select rose mid bit");
   property p_whole_bytes;
      $rose(chip_select_in_n) |-> bits_q == 3'h0;
   endproperty
   a_whole_bytes: assert property (p_whole_bytes) else $error("frame not whole bytes");
   property p_sdo_idle_high;
      idle_q >= 4'h8 |-> sdo;
   endproperty
   a_sdo_idle_high: assert property (p_sdo_idle_high) else $error("sdo low while deselected");
   c_frame_end: cover property ($rose(chip_select_in_n));
   c_read_zero: cover property (!chip_select_in_n && $fell(sdo));
   c_poll_release: cover property (!chip_select_in_n && sck && $rose(sdo));
endmodule

// ===== tb/tb_top.sv
// testbench: host and monitor ends joined over the link, driven through axi4-lite
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top
   import cmd_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [4:0] awaddr = 5'h0, araddr = 5'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, busy, dis;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [11:0] conv_value = 12'h0;
   logic [23:0] flag_bits = 24'h0;
   logic int_pending = 1'b0;
   logic [3:0] kind, chan;
   logic [47:0] cfg_grp;
   logic [7:0] tst;
   logic [7:0] txb [0:19];
   logic [7:0] rxb [0:19];
   logic [7:0] expb [0:19];
   logic [11:0] cells [1:12];
   bit ten = 0;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;
   cmd_link_if link ();
   cmd_host i_cmd_host (.clk(clk), .arst_n(arst_n), .link(link), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cmd_device i_cmd_device (.clk(clk), .arst_n(arst_n), .link(link), .conv_value(conv_value),
      .temp_status(2'b00), .flag_bits(flag_bits), .int_pending(int_pending), .busy(busy),
      .discharge_active(dis), .conv_kind(kind), .conv_channel(chan), .config_group(cfg_grp),
      .temp_self_test(tst));
   cmd_monitor i_cmd_monitor (.clk(clk), .arst_n(arst_n), .chip_select_in_n(link.chip_select_in_n),
      .sck(link.sck), .sdi(link.sdi), .sdo(link.sdo));
   // clock and hang guard; a full run needs well under half the ceiling
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // axi writes offer address and data together, each dropped once taken
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // one byte each way on the link
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(REG_TXDATA, {24'h0, tx}, r);
      do axi_rd(REG_STATUS, d, r); while (d[0] === 1'b1);
      axi_rd(REG_RXDATA, d, r);
      rx = d[7:0];
   endtask
   // device wants a few idle cycles around select changes
   task automatic sel(input logic on);
      logic [1:0] r;
      axi_wr(REG_CTRL, {31'h0, on}, r);
      repeat (4) @(posedge clk);
   endtask
   task automatic frame(input logic [7:0] c, input int n, input bit keep);
      logic [7:0] dummy;
      sel(1'b1);
      xfer(c, dummy);
      for (int i = 0; i < n; i++) xfer(txb[i], rxb[i]);
      if (!keep) sel(1'b0);
   endtask
   task automatic check_group(input int n);
      logic [7:0] crc;
      crc = 8'h00;
      for (int i = 0; i < n; i++) begin
         `CHK(rxb[i], expb[i])
         for (int b = 7; b >= 0; b--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ expb[i][b]) ? CRC_POLY : 8'h00);
      end
      `CHK(rxb[n], crc)
   endtask
   task automatic cfg(input logic [7:0] b0, input int n);
      txb[0] = b0;
      for (int i = 1; i < 6; i++) txb[i] = 8'(i * 17);
      frame(CMD_WRITE_CONFIG, n, 1'b0);
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge clk);
      `CHK(busy, 1'b0)
   endtask
   task automatic poll_sdo(input logic e);
      logic [31:0] d;
      logic [1:0] r;
      for (int n = 0; n < 30; n++) begin
         axi_rd(REG_STATUS, d, r);
         if (d[1] === e) break;
      end
      `CHK(d[1], e)
   endtask
   // start a conversion, then update the expected cell table
   task automatic convert(input logic [7:0] c);
      logic [3:0] s;
      s = c[3:0];
      frame(c, 0, 1'b0);
      `CHK(busy, 1'b1)
      `CHK(kind, c[7:4])
      `CHK(chan, s)
      `CHK(dis, c[6])
      wait_idle();
      for (int i = 1; i <= 12 && c[7:4] != FAM_TEMP; i++) begin
         if (s == SUB_SELF_TEST1) cells[i] = SELF_TEST1_VALUE;
         else if (s == SUB_SELF_TEST2) cells[i] = SELF_TEST2_VALUE;
         else if ((s == SUB_ALL && (i <= 10 || !ten)) || s == 4'(i)) cells[i] = conv_value;
      end
   endtask
   task automatic ign(input logic [7:0] c);
      logic [3:0] k;
      k = kind;
      frame(c, 0, 1'b0);
      `CHK(busy, 1'b0)
      `CHK(kind, k)
      `CHK(cfg_grp, 48'h5544_3322_1108)
   endtask
   task automatic read_cells(input int n);
      for (int p = 0; p < 6; p++) begin
         expb[3 * p] = cells[2 * p + 1][7:0];
         expb[3 * p + 1] = {cells[2 * p + 2][3:0], cells[2 * p + 1][11:8]};
         expb[3 * p + 2] = cells[2 * p + 2][11:4];
      end
      frame(CMD_READ_CELLS, n + 1, 1'b0);
      check_group(n);
   endtask
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      `CHK(cfg_grp, 48'h0)
      `CHK(busy, 1'b0)
      axi_rd(5'h10, d, r);
      `CHK(r, RESP_SLVERR)
      `CHK(d, 32'h0)
      axi_wr(5'h14, 32'h1, r);
      `CHK(r, RESP_SLVERR)
      `CHK(link.chip_select_in_n, 1'b1)
      $display("test reset done");
   endtask
   task automatic t_config();
      cfg(8'h02, 6);
      `CHK(cfg_grp, 48'h5544_3322_1102)
      expb[0] = 8'h02;
      for (int i = 1; i < 6; i++) expb[i] = 8'(i * 17);
      frame(CMD_READ_CONFIG, 7, 1'b0);
      check_group(6);
      cfg(8'h07, 3);
      `CHK(cfg_grp, 48'h5544_3322_1102)
      $display("test config done");
   endtask
   task automatic t_cells();
      conv_value <= 12'habc;
      convert(8'h10);
      conv_value <= 12'h123;
      convert(8'h6c);
      conv_value <= 12'h456;
      convert(8'h21);
      convert(8'h7a);
      read_cells(18);
      convert(8'h1e);
      read_cells(18);
      convert(8'h7f);
      read_cells(18);
      $display("test cells done");
   endtask
   task automatic t_tencell();
      logic [7:0] bad [5] = '{8'h1b, 8'h6c, 8'h2d, 8'h34, 8'h03};
      cfg(8'h08, 6);
      ten = 1;
      conv_value <= 12'h0f0;
      convert(8'h60);
      foreach (bad[i]) ign(bad[i]);
      read_cells(15);
      flag_bits <= 24'h5aa5c3;
      expb[0] = 8'hc3;
      expb[1] = 8'ha5;
      expb[2] = 8'h5a;
      frame(CMD_READ_FLAGS, 4, 1'b0);
      check_group(3);
      convert(8'h3e);
      `CHK(tst, 8'h01)
      convert(8'h3f);
      `CHK(tst, 8'h02)
      convert(8'h33);
      `CHK(tst, 8'h00)
      for (int i = 0; i < 5; i++) expb[i] = 8'h00;
      frame(CMD_READ_TEMPS, 6, 1'b0);
      check_group(5);
      $display("test ten cell done");
   endtask
   task automatic t_poll();
      cfg(8'h10, 6);
      ten = 0;
      frame(8'h11, 0, 1'b1);
      poll_sdo(1'b0);
      wait_idle();
      poll_sdo(1'b1);
      sel(1'b0);
      int_pending <= 1'b1;
      frame(CMD_POLL_INT, 0, 1'b1);
      poll_sdo(1'b0);
      int_pending <= 1'b0;
      poll_sdo(1'b1);
      sel(1'b0);
      frame(CMD_POLL_BUSY, 0, 1'b1);
      poll_sdo(1'b1);
      sel(1'b0);
      $display("test poll done");
   endtask
   initial begin
      for (int i = 0; i < 20; i++) txb[i] = 8'hff;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_config();
      t_cells();
      t_tencell();
      t_poll();
      summarize();
   end
endmodule
